// [src/energy_hysteresis_pkg.sv]
/*
 * Package for the energy and hysteresis register group: command codes,
 * field positions, reset values and the carrier structs.
 * Assumes the including design runs on one clock with an active-low reset.
 */
package energy_hysteresis_pkg;

	// Command codes on the management command port
	localparam logic [7:0] CMD_EXT_INPUT_POWER   = 8'hdb;
	localparam logic [7:0] CMD_ENERGY_SNAPSHOT   = 8'hdc;
	localparam logic [7:0] CMD_BAND_FLOOR        = 8'hf2;
	localparam logic [7:0] CMD_BAND_CEILING      = 8'hf3;
	localparam logic [7:0] CMD_BAND_STATE_FLAGS  = 8'hf4;
	localparam logic [7:0] CMD_INRUSH_LIMIT      = 8'hf6;

	// Reply lengths in bytes
	localparam logic [3:0] LEN_EXT_INPUT_POWER   = 4'h3;
	localparam logic [3:0] LEN_ENERGY_SNAPSHOT   = 4'h8;
	localparam logic [3:0] LEN_WORD              = 4'h2;
	localparam logic [3:0] LEN_BYTE              = 4'h1;
	localparam logic [3:0] LEN_NONE              = 4'h0;

	// Energy snapshot field positions
	localparam int SNAP_COUNT_LSB   = 40;
	localparam int SNAP_WRAP_LSB    = 24;
	localparam int SNAP_ENERGY_LSB  = 0;

	// Band state flag positions
	localparam int FLAG_BELOW_FLOOR    = 0;
	localparam int FLAG_ABOVE_CEILING  = 1;
	localparam int FLAG_COMPARE_LEVEL  = 2;
	localparam int FLAG_OVERCURRENT    = 3;

	// Reset values
	localparam logic [23:0] RST_EXT_INPUT_POWER = 24'h00_0000;
	localparam logic [23:0] RST_SAMPLE_COUNT    = 24'h00_0000;
	localparam logic [15:0] RST_WRAP_TALLY      = 16'h0000;
	localparam logic [23:0] RST_ENERGY          = 24'h00_0000;
	localparam logic [15:0] RST_BAND_FLOOR      = 16'h0000;
	localparam logic [15:0] RST_BAND_CEILING    = 16'hffff;
	localparam logic [7:0]  RST_BAND_FLAGS      = 8'h00;
	localparam logic [3:0]  RST_INRUSH_SCALE    = 4'hf;
	localparam logic [15:0] RST_CURRENT_LIMIT   = 16'h0000;

	// Accumulator wraps from this value back to zero
	localparam logic [23:0] ENERGY_WRAP_MAX     = 24'h7f_ffff;

	// Measurement results handed in by the analog front end logic
	typedef struct packed {
		logic [23:0] extPower;
		logic        extPowerValid;
		logic [15:0] energyIncrement;
		logic        energyValid;
		logic [15:0] bandPower;
		logic [15:0] bandCurrent;
	} measurement_s;

	// Reply to a command port read
	typedef struct packed {
		logic        valid;
		logic        unmapped;
		logic [3:0]  length;
		logic [63:0] data;
	} read_reply_s;

endpackage

// [src/energy_hysteresis_regs.sv]
/*
 * Energy snapshot, extended input power, hysteretic band comparator and
 * start-up current limit scaling, reached over the management command port.
 * Assumes the bus protocol engine decodes transactions into one-cycle read
 * and write strobes with the command code, and that all measurement inputs
 * come from logic on the same clock.
 */
`timescale 1ns/1ns

module energy_hysteresis_regs (
	input  wire logic                                 clock,
	input  wire logic                                 resetn,
	// Command port from the bus protocol engine
	input  wire logic [7:0]                           cmdCode,
	input  wire logic                                 cmdWrite,
	input  wire logic                                 cmdRead,
	input  wire logic [15:0]                          cmdWriteData,
	output energy_hysteresis_pkg::read_reply_s        readReply,
	// Measurement side
	input  wire energy_hysteresis_pkg::measurement_s  meas,
	input  wire logic                                 powerBandSelect,
	input  wire logic                                 outputOvercurrentAlarm,
	// Current limit side
	input  wire logic                                 startupPhase,
	input  wire logic [15:0]                          inrushFullLimit,
	input  wire logic [15:0]                          runLimit,
	output logic [15:0]                               currentLimit,
	output logic                                      bandCompareLevel
);

	// Register state
	logic [23:0] extInputPower_q;
	logic [23:0] sampleCount_q;
	logic [15:0] accumulatorWrapTally_q;
	logic [23:0] energyAccumulator_q;
	logic [15:0] bandFloor_q;
	logic [15:0] bandCeiling_q;
	logic        aboveCeilingFlag_q;
	logic        belowFloorFlag_q;
	logic        bandCompareLevel_q;
	logic        outputOvercurrentAlarm_q;
	logic [3:0]  inrushLimitScale_q;
	logic [15:0] currentLimit_q;
	energy_hysteresis_pkg::read_reply_s readReply_q;

	// Next values and helpers
	logic [24:0] energySum;
	logic [23:0] energyAccumulator_d;
	logic        energyWrap;
	logic [15:0] comparedValue;
	logic        aboveCeiling;
	logic        belowFloor;
	logic        bandCompareLevel_d;
	logic [20:0] scaledProduct;
	logic [15:0] scaledLimit;
	logic [7:0]  bandStateFlags;
	logic [63:0] energySnapshot;
	energy_hysteresis_pkg::read_reply_s readReply_d;

	// Write decode; writes to read-only or unknown codes are dropped
	logic writeFloor;
	logic writeCeiling;
	logic writeScale;

	always_comb begin
		writeFloor   = 1'b0;
		writeCeiling = 1'b0;
		writeScale   = 1'b0;
		if (cmdWrite && cmdCode == energy_hysteresis_pkg::CMD_BAND_FLOOR) begin
			writeFloor = 1'b1;
		end else if (cmdWrite && cmdCode == energy_hysteresis_pkg::CMD_BAND_CEILING) begin
			writeCeiling = 1'b1;
		end else if (cmdWrite && cmdCode == energy_hysteresis_pkg::CMD_INRUSH_LIMIT) begin
			writeScale = 1'b1;
		end
	end

	hold_reg #(
		.WIDTH       (24),
		.RESET_VALUE (energy_hysteresis_pkg::RST_EXT_INPUT_POWER)
	) ext_power_reg (
		.clock  (clock),
		.resetn (resetn),
		.load   (meas.extPowerValid),
		.d      (meas.extPower),
		.q      (extInputPower_q)
	);

	// Accumulator sum; increment is 16 bits so one wrap at most per sample
	always_comb begin
		energySum           = {1'b0, energyAccumulator_q} + {9'h000, meas.energyIncrement};
		energyWrap          = energySum > {1'b0, energy_hysteresis_pkg::ENERGY_WRAP_MAX};
		energyAccumulator_d = energySum[23:0];
		if (energyWrap) begin
			energyAccumulator_d = energySum[23:0] - (energy_hysteresis_pkg::ENERGY_WRAP_MAX + 24'h00_0001);
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sampleCount_q <= energy_hysteresis_pkg::RST_SAMPLE_COUNT;
		end else if (meas.energyValid) begin
			sampleCount_q <= sampleCount_q + 24'h00_0001; // Free-running, wraps silently
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			accumulatorWrapTally_q <= energy_hysteresis_pkg::RST_WRAP_TALLY;
		end else if (meas.energyValid && energyWrap) begin
			accumulatorWrapTally_q <= accumulatorWrapTally_q + 16'h0001;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			energyAccumulator_q <= energy_hysteresis_pkg::RST_ENERGY;
		end else if (meas.energyValid) begin
			energyAccumulator_q <= energyAccumulator_d;
		end
	end

	hold_reg #(
		.WIDTH       (16),
		.RESET_VALUE (energy_hysteresis_pkg::RST_BAND_FLOOR)
	) band_floor_reg (
		.clock  (clock),
		.resetn (resetn),
		.load   (writeFloor),
		.d      (cmdWriteData),
		.q      (bandFloor_q)
	);

	// upper band threshold
	// All ones after reset keeps the comparator low until software programs a band
	hold_reg #(
		.WIDTH       (16),
		.RESET_VALUE (energy_hysteresis_pkg::RST_BAND_CEILING)
	) band_ceiling_reg (
		.clock  (clock),
		.resetn (resetn),
		.load   (writeCeiling),
		.d      (cmdWriteData),
		.q      (bandCeiling_q)
	);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			inrushLimitScale_q <= energy_hysteresis_pkg::RST_INRUSH_SCALE;
		end else if (writeScale) begin
			inrushLimitScale_q <= cmdWriteData[3:0]; // Upper bits have no storage
		end
	end

	// Band comparison on the selected quantity
	always_comb begin
		comparedValue = powerBandSelect ? meas.bandPower : meas.bandCurrent;
		aboveCeiling  = comparedValue > bandCeiling_q;
		belowFloor    = comparedValue < bandFloor_q;
		bandCompareLevel_d = bandCompareLevel_q;
		if (aboveCeiling) begin
			bandCompareLevel_d = 1'b1; // Rising wins if thresholds are crossed over
		end else if (belowFloor) begin
			bandCompareLevel_d = 1'b0;
		end
	end

	// above ceiling flag
	// Live flags load every cycle; only the compare level holds its state, and there set wins over clear
	hold_reg #(
		.WIDTH       (1),
		.RESET_VALUE (energy_hysteresis_pkg::RST_BAND_FLAGS[energy_hysteresis_pkg::FLAG_ABOVE_CEILING])
	) above_flag_reg (
		.clock  (clock),
		.resetn (resetn),
		.load   (1'b1),
		.d      (aboveCeiling),
		.q      (aboveCeilingFlag_q)
	);

	hold_reg #(
		.WIDTH       (1),
		.RESET_VALUE (energy_hysteresis_pkg::RST_BAND_FLAGS[energy_hysteresis_pkg::FLAG_BELOW_FLOOR])
	) below_flag_reg (
		.clock  (clock),
		.resetn (resetn),
		.load   (1'b1),
		.d      (belowFloor),
		.q      (belowFloorFlag_q)
	);

	hold_reg #(
		.WIDTH       (1),
		.RESET_VALUE (energy_hysteresis_pkg::RST_BAND_FLAGS[energy_hysteresis_pkg::FLAG_COMPARE_LEVEL])
	) level_flag_reg (
		.clock  (clock),
		.resetn (resetn),
		.load   (1'b1),
		.d      (bandCompareLevel_d),
		.q      (bandCompareLevel_q)
	);

	hold_reg #(
		.WIDTH       (1),
		.RESET_VALUE (energy_hysteresis_pkg::RST_BAND_FLAGS[energy_hysteresis_pkg::FLAG_OVERCURRENT])
	) alarm_flag_reg (
		.clock  (clock),
		.resetn (resetn),
		.load   (1'b1),
		.d      (outputOvercurrentAlarm),
		.q      (outputOvercurrentAlarm_q)
	);

	// Start-up limit scaling; product of 16 by 5 bits never exceeds full level after shift
	always_comb begin
		scaledProduct = inrushFullLimit * ({1'b0, inrushLimitScale_q} + 5'h01);
		scaledLimit   = scaledProduct[19:4];
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			currentLimit_q <= energy_hysteresis_pkg::RST_CURRENT_LIMIT; // Safest limit until the first edge
		end else if (startupPhase) begin
			currentLimit_q <= scaledLimit;
		end else begin
			currentLimit_q <= runLimit;
		end
	end

	// Read images
	always_comb begin
		bandStateFlags                                          = energy_hysteresis_pkg::RST_BAND_FLAGS;
		bandStateFlags[energy_hysteresis_pkg::FLAG_BELOW_FLOOR]   = belowFloorFlag_q;
		bandStateFlags[energy_hysteresis_pkg::FLAG_ABOVE_CEILING] = aboveCeilingFlag_q;
		bandStateFlags[energy_hysteresis_pkg::FLAG_COMPARE_LEVEL] = bandCompareLevel_q;
		bandStateFlags[energy_hysteresis_pkg::FLAG_OVERCURRENT]   = outputOvercurrentAlarm_q;
		energySnapshot = 64'h0000_0000_0000_0000;
		energySnapshot[energy_hysteresis_pkg::SNAP_COUNT_LSB +: 24]  = sampleCount_q;
		energySnapshot[energy_hysteresis_pkg::SNAP_WRAP_LSB +: 16]   = accumulatorWrapTally_q;
		energySnapshot[energy_hysteresis_pkg::SNAP_ENERGY_LSB +: 24] = energyAccumulator_q;
	end

	// Read decode; unknown codes answer with zero data and a marker
	always_comb begin
		readReply_d          = '0;
		readReply_d.valid    = cmdRead;
		if (!cmdRead) begin
			readReply_d.valid = 1'b0;
		end else if (cmdCode == energy_hysteresis_pkg::CMD_EXT_INPUT_POWER) begin
			readReply_d.length     = energy_hysteresis_pkg::LEN_EXT_INPUT_POWER;
			readReply_d.data[23:0] = extInputPower_q;
		end else if (cmdCode == energy_hysteresis_pkg::CMD_ENERGY_SNAPSHOT) begin
			readReply_d.length = energy_hysteresis_pkg::LEN_ENERGY_SNAPSHOT;
			readReply_d.data   = energySnapshot;
		end else if (cmdCode == energy_hysteresis_pkg::CMD_BAND_FLOOR) begin
			readReply_d.length     = energy_hysteresis_pkg::LEN_WORD;
			readReply_d.data[15:0] = bandFloor_q;
		end else if (cmdCode == energy_hysteresis_pkg::CMD_BAND_CEILING) begin
			readReply_d.length     = energy_hysteresis_pkg::LEN_WORD;
			readReply_d.data[15:0] = bandCeiling_q;
		end else if (cmdCode == energy_hysteresis_pkg::CMD_BAND_STATE_FLAGS) begin
			readReply_d.length    = energy_hysteresis_pkg::LEN_BYTE;
			readReply_d.data[7:0] = bandStateFlags;
		end else if (cmdCode == energy_hysteresis_pkg::CMD_INRUSH_LIMIT) begin
			readReply_d.length    = energy_hysteresis_pkg::LEN_WORD;
			readReply_d.data[3:0] = inrushLimitScale_q;
		end else begin
			readReply_d.unmapped = 1'b1;
			readReply_d.length   = energy_hysteresis_pkg::LEN_NONE;
		end
	end

	// Reply register; captured in the strobe cycle so the snapshot cannot tear
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			readReply_q <= '0;
		end else begin
			readReply_q <= readReply_d;
		end
	end

	// Outputs straight from flops
	assign readReply        = readReply_q;
	assign currentLimit     = currentLimit_q;
	assign bandCompareLevel = bandCompareLevel_q;

endmodule // energy_hysteresis_regs

// Loadable register with a fixed value after reset
// Shared by thresholds and live flags so reset handling stays uniform
module hold_reg #(
	parameter int               WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input  wire logic             clock,
	input  wire logic             resetn,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0]      q
);

	// Async clear to the reset value, load otherwise
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			q <= RESET_VALUE;
		end else if (load) begin
			q <= d;
		end
	end

endmodule // hold_reg

// [test/energy_hysteresis_regs_sva.sv]
/* Port assertions for the energy and band register group.
   Assumes one clock domain and an active-low asynchronous reset. */
`timescale 1ns/1ns
module energy_hysteresis_regs_sva (
	input wire logic                               clock,
	input wire logic                               resetn,
	input wire logic [7:0]                         cmdCode,
	input wire logic                               cmdRead,
	input wire energy_hysteresis_pkg::read_reply_s readReply,
	input wire logic                               outputOvercurrentAlarm,
	input wire logic                               startupPhase,
	input wire logic [15:0]                        runLimit,
	input wire logic [15:0]                        currentLimit,
	input wire logic                               bandCompareLevel
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	// Reply framing and field padding
	reply_next_a: assert property (cmdRead |=> readReply.valid)
		else $error("read without reply");
	reply_idle_a: assert property (!cmdRead |=> readReply == '0)
		else $error("reply outside read");
	power_width_a: assert property (cmdRead && cmdCode == 8'hdb |=>
		readReply.length == 4'h3 && readReply.data[63:24] == '0) else $error("power reply shape");
	snap_len_a: assert property (cmdRead && cmdCode == 8'hdc |=>
		readReply.length == 4'h8 && !readReply.unmapped) else $error("snapshot reply shape");
	flag_pad_a: assert property (cmdRead && cmdCode == 8'hf4 |=>
		readReply.length == 4'h1 && readReply.data[63:4] == '0) else $error("flag padding");
	scale_pad_a: assert property (cmdRead && cmdCode == 8'hf6 |=> readReply.data[63:4] == '0)
		else $error("scale padding");
	// Flags are one register stage behind their sources
	level_flag_a: assert property (cmdRead && cmdCode == 8'hf4 |=>
		readReply.data[2] == $past(bandCompareLevel)) else $error("level flag");
	alarm_flag_a: assert property (cmdRead && cmdCode == 8'hf4 && $past(resetn) |=>
		readReply.data[3] == $past(outputOvercurrentAlarm, 2)) else $error("alarm flag");
	run_limit_a: assert property (!startupPhase |=> currentLimit == $past(runLimit))
		else $error("run limit");

	cover property (cmdRead && cmdCode == 8'hdc);
	cover property ($rose(bandCompareLevel));
	cover property (startupPhase);
endmodule // energy_hysteresis_regs_sva

bind energy_hysteresis_regs energy_hysteresis_regs_sva sva (.clock(clock), .resetn(resetn), .cmdCode(cmdCode),
	.cmdRead(cmdRead), .readReply(readReply), .outputOvercurrentAlarm(outputOvercurrentAlarm),
	.startupPhase(startupPhase), .runLimit(runLimit), .currentLimit(currentLimit),
	.bandCompareLevel(bandCompareLevel));

// [test/host_model.sv]
/* Host side of the command port: one strobe per request.
   Assumes the bench clock and a registered one-cycle reply. */
`timescale 1ns/1ns
module host_model (
	input  wire logic                               clock,
	output logic [7:0]                              cmdCode,
	output logic                                    cmdWrite,
	output logic                                    cmdRead,
	output logic [15:0]                             cmdWriteData,
	input  wire energy_hysteresis_pkg::read_reply_s readReply
);
	// Idle bus at time zero
	initial begin
		cmdCode = 8'h00;
		cmdWrite = 1'b0;
		cmdRead = 1'b0;
		cmdWriteData = 16'h0000;
	end

	// Lines inverted after use so stale values never pass
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(posedge clock);
		cmdCode <= c;
		cmdWriteData <= d;
		cmdWrite <= 1'b1;
		@(posedge clock);
		cmdWrite <= 1'b0;
		cmdCode <= ~c;
		cmdWriteData <= ~d;
	endtask

	task automatic rd(input logic [7:0] c, output energy_hysteresis_pkg::read_reply_s r);
		@(posedge clock);
		cmdCode <= c;
		cmdRead <= 1'b1;
		@(posedge clock);
		cmdRead <= 1'b0;
		cmdCode <= ~c;
		#1 r = readReply;
	endtask
endmodule // host_model

// [test/energy_hysteresis_regs_tb_top.sv]
/* Self-checking bench for the register group with a behavioural model.
   Assumes the host model drives the command port. */
`timescale 1ns/1ns
module energy_hysteresis_regs_tb_top;
	logic                                clock = 1'b0;
	logic                                resetn = 1'b0;
	logic [7:0]                          cmdCode;
	logic                                cmdWrite;
	logic                                cmdRead;
	logic [15:0]                         cmdWriteData;
	energy_hysteresis_pkg::read_reply_s  readReply;
	energy_hysteresis_pkg::read_reply_s  r;
	energy_hysteresis_pkg::measurement_s meas = '0;
	logic                                powerBandSelect = 1'b0;
	logic                                alm = 1'b0;
	logic                                startupPhase = 1'b0;
	logic [15:0]                         inrushFullLimit = '0;
	logic [15:0]                         runLimit = '0;
	logic [15:0]                         currentLimit;
	logic                                bandCompareLevel;
	logic [31:0]                         seed = 32'd96766;
	logic [31:0]                         d;
	logic [7:0]                          codes [7] = '{8'hdb, 8'hdc, 8'hf2, 8'hf3, 8'hf4, 8'hf6, 8'h00};
	logic [15:0]                         vals [5] = '{16'h0500, 16'h4000, 16'h9000, 16'h4000, 16'h0800};
	int n_fail, total_checks, cyc, extM, countM, tallyM, accM, floorM, levelM;
	int ceilM = 16'hffff;
	int scaleM = 15;

	always #4 clock = ~clock;

	host_model host (.clock(clock), .cmdCode(cmdCode), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
		.cmdWriteData(cmdWriteData), .readReply(readReply));
	energy_hysteresis_regs dut (.clock(clock), .resetn(resetn), .cmdCode(cmdCode), .cmdWrite(cmdWrite),
		.cmdRead(cmdRead), .cmdWriteData(cmdWriteData), .readReply(readReply), .meas(meas),
		.powerBandSelect(powerBandSelect), .outputOvercurrentAlarm(alm), .startupPhase(startupPhase),
		.inrushFullLimit(inrushFullLimit), .runLimit(runLimit), .currentLimit(currentLimit),
		.bandCompareLevel(bandCompareLevel));

	// Hang guard, well above the roughly 800 cycles used
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			test_done();
		end
	end

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Expected {length, data} from the model state
	function automatic logic [67:0] expRead(input logic [7:0] c);
		logic [15:0] v;
		v = powerBandSelect ? meas.bandPower : meas.bandCurrent;
		case (c)
			8'hdb: return {4'h3, 40'h0, extM[23:0]};
			8'hdc: return {4'h8, countM[23:0], tallyM[15:0], accM[23:0]};
			8'hf2: return {4'h2, 48'h0, floorM[15:0]};
			8'hf3: return {4'h2, 48'h0, ceilM[15:0]};
			8'hf4: return {4'h1, 60'h0, alm, levelM[0], v > ceilM[15:0], v < floorM[15:0]};
			8'hf6: return {4'h2, 60'h0, scaleM[3:0]};
			default: return 68'h0;
		endcase
	endfunction

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rdChk(input logic [7:0] c);
		logic [67:0] e;
		e = expRead(c);
		host.rd(c, r);
		chk({r.valid, r.unmapped, r.length}, {1'b1, e[67:64] == 4'h0, e[67:64]});
		chk(r.data, e[63:0]);
	endtask

	// Lets flags catch up; set wins over clear
	task automatic settle();
		int v;
		repeat (3) @(posedge clock);
		v = powerBandSelect ? meas.bandPower : meas.bandCurrent;
		if (v > ceilM) levelM = 1;
		else if (v < floorM) levelM = 0;
	endtask

	task automatic test_done();
		if (n_fail == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		// Reset values, then writes to every code incl. read-only and unmapped
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 7 && p == 1; i++) begin
				d = rnd();
				host.wr(codes[i], d[15:0]);
				case (codes[i])
					8'hf2: floorM = d[15:0];
					8'hf3: ceilM = d[15:0];
					8'hf6: scaleM = d[3:0];
					default: ;
				endcase
			end
			settle();
			foreach (codes[i]) rdChk(codes[i]);
		end
		// Back-to-back samples drive the accumulator through wraps
		for (int i = 0; i < 600; i++) begin
			@(posedge clock);
			d = rnd();
			meas.energyValid <= 1'b1;
			meas.energyIncrement <= {1'b1, d[14:0]};
			meas.extPowerValid <= 1'b1;
			meas.extPower <= d[31:8];
			extM = d[31:8];
			countM++;
			accM += {1'b1, d[14:0]};
			if (accM > 24'h7f_ffff) begin
				accM -= 24'h80_0000;
				tallyM++;
			end
		end
		@(posedge clock);
		meas.energyValid <= 1'b0;
		meas.extPowerValid <= 1'b0;
		rdChk(8'hdc);
		rdChk(8'hdb);
		// Band walk for both sources; unselected source is inverted
		host.wr(8'hf2, 16'h1000);
		host.wr(8'hf3, 16'h8000);
		floorM = 16'h1000;
		ceilM = 16'h8000;
		for (int i = 0; i < 10; i++) begin
			@(posedge clock);
			d = rnd();
			powerBandSelect <= (i >= 5);
			meas.bandPower <= (i >= 5) ? vals[i % 5] : ~vals[i % 5];
			meas.bandCurrent <= (i >= 5) ? ~vals[i % 5] : vals[i % 5];
			alm <= d[0];
			settle();
			rdChk(8'hf4);
			chk(bandCompareLevel, levelM[0]);
		end
		// Every scale code during start-up
		@(posedge clock);
		d = rnd();
		inrushFullLimit <= d[15:0];
		startupPhase <= 1'b1;
		for (int n = 0; n < 16; n++) begin
			host.wr(8'hf6, {d[31:20], n[3:0]});
			scaleM = n;
			rdChk(8'hf6);
			chk(currentLimit, d[15:0] * (n + 1) / 16);
		end
		@(posedge clock);
		startupPhase <= 1'b0;
		runLimit <= d[31:16];
		repeat (2) @(posedge clock);
		#1 chk(currentLimit, d[31:16]);
		test_done();
	end
endmodule // energy_hysteresis_regs_tb_top
